// ==== gpiop_params.svh ====
// Constants for the open-drain multi-function pin bank
`ifndef GPIOP_PARAMS_SVH
`define GPIOP_PARAMS_SVH

`define GPIOP_NPINS      16
`define GPIOP_OBS_SEL_W  4
`define GPIOP_OBS_W      16
`define GPIOP_RATE_W     2
`define GPIOP_PHASE_W    4
`define GPIOP_BLINK_DIV  25000000
`define GPIOP_CFG_CHAN   3'h0
`define GPIOP_CFG_DEVGRP 5'h1E
`define GPIOP_CFG_REGNUM 16'h0100
`define GPIOP_PIN_SSDA   2
`define GPIOP_PIN_SSCL   3
`define GPIOP_PIN_MSDA   6
`define GPIOP_PIN_MSCL   7

`endif

// ==== gpiop_pkg.sv ====
// Types shared by the pin bank modules
package gpiop_pkg;
	// Pin function selection
	typedef enum logic [1:0] {
		GPIOP_FUNC_IO      = 2'h0,
		GPIOP_FUNC_OBSERVE = 2'h1,
		GPIOP_FUNC_PERIPH  = 2'h2
	} gpiop_func_type;
endpackage : gpiop_pkg

// ==== gpiop_pin.sv ====
// One open-drain pin: configuration, input sync, change detect and driver select
`include "gpiop_params.svh"
module gpiop_pin #(
	parameter gpiop_pkg::gpiop_func_type RESET_FUNC = gpiop_pkg::GPIOP_FUNC_IO
) (
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_rst,
	input  wire logic                            i_cfg_wr,
	input  wire gpiop_pkg::gpiop_func_type       i_cfg_func,
	input  wire logic                            i_cfg_out_en,
	input  wire logic                            i_cfg_level,
	input  wire logic                            i_cfg_blink_en,
	input  wire logic [`GPIOP_RATE_W-1:0]        i_cfg_blink_rate,
	input  wire logic                            i_cfg_irq_en,
	input  wire logic [`GPIOP_OBS_SEL_W-1:0]     i_cfg_obs_sel,
	input  wire logic                            i_pend_clr,
	input  wire logic [`GPIOP_PHASE_W-1:0]       i_blink_phase,
	input  wire logic [`GPIOP_OBS_W-1:0]         i_observe,
	input  wire logic                            i_periph_low,
	input  wire logic                            i_pad_in,
	output logic                                 o_drive_low,
	output logic                                 o_level,
	output logic                                 o_pend,
	output gpiop_pkg::gpiop_func_type            o_func
);
	import gpiop_pkg::*;

	gpiop_func_type              func_r;
	logic                        out_en_r;
	logic                        level_r;
	logic                        blink_en_r;
	logic [`GPIOP_RATE_W-1:0]    rate_r;
	logic                        irq_en_r;
	logic [`GPIOP_OBS_SEL_W-1:0] obs_sel_r;
	logic                        sync1_r;
	logic                        sync2_r;
	logic                        prev_r;
	logic                        drive_low_r;
	logic                        pend_r;
	logic                        blink_bit;
	logic                        io_low;
	logic                        obs_low;
	logic                        drive_nxt;
	logic                        pend_set;
	logic                        pend_nxt;

	// -----------------------------------------------------------------
	// Configuration registers
	// -----------------------------------------------------------------
	// Function resets per pin so the serial slave pins come up usable
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			func_r     <= RESET_FUNC;
			out_en_r   <= 1'b0;
			level_r    <= 1'b1;
			blink_en_r <= 1'b0;
			rate_r     <= '0;
			irq_en_r   <= 1'b0;
			obs_sel_r  <= '0;
		end else if (i_cfg_wr) begin
			func_r     <= i_cfg_func;
			out_en_r   <= i_cfg_out_en;
			level_r    <= i_cfg_level;
			blink_en_r <= i_cfg_blink_en;
			rate_r     <= i_cfg_blink_rate;
			irq_en_r   <= i_cfg_irq_en;
			obs_sel_r  <= i_cfg_obs_sel;
		end
	end

	// -----------------------------------------------------------------
	// Driver selection
	// -----------------------------------------------------------------
	// Low level or blink phase pulls the pin; high just releases it
	assign blink_bit = i_blink_phase[rate_r];
	assign io_low    = out_en_r & (blink_en_r ? blink_bit : ~level_r);
	assign obs_low   = ~i_observe[obs_sel_r];

	always_comb begin
		case (func_r)
			GPIOP_FUNC_IO:      drive_nxt = io_low;
			GPIOP_FUNC_OBSERVE: drive_nxt = obs_low;
			GPIOP_FUNC_PERIPH:  drive_nxt = i_periph_low;
			default:            drive_nxt = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------
	// Input sync, change detect, pending flag
	// -----------------------------------------------------------------
	assign pend_set = (sync2_r ^ prev_r) & (func_r == GPIOP_FUNC_IO) & ~out_en_r & irq_en_r;
	assign pend_nxt = pend_set | (pend_r & ~i_pend_clr); // Set beats a same-cycle clear

	// One register holds the drive, so enable and level switch together
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sync1_r     <= 1'b1;
			sync2_r     <= 1'b1;
			prev_r      <= 1'b1;
			drive_low_r <= 1'b0;
			pend_r      <= 1'b0;
		end else begin
			sync1_r     <= i_pad_in;
			sync2_r     <= sync1_r;
			prev_r      <= sync2_r;
			drive_low_r <= drive_nxt;
			pend_r      <= pend_nxt;
		end
	end

	assign o_drive_low = drive_low_r;
	assign o_level     = sync2_r;
	assign o_pend      = pend_r;
	assign o_func      = func_r;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	input_release_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(func_r == GPIOP_FUNC_IO && !out_en_r) |=> !o_drive_low)
		else $error("input-mode pin was pulled low");
	observe_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(func_r == GPIOP_FUNC_OBSERVE) |=> (o_drive_low == !$past(i_observe[obs_sel_r])))
		else $error("observed signal not on pin");
	sync_delay_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$past(i_rst, 3) == 1'b0 |-> (o_level == $past(i_pad_in, 2)))
		else $error("level not two stages behind pad");
	pend_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		pend_set |=> o_pend)
		else $error("pin change lost");
	pend_cause_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(!o_pend && !(irq_en_r && func_r == GPIOP_FUNC_IO && !out_en_r)) |=> !o_pend)
		else $error("pending set without enable");
	level_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(func_r == GPIOP_FUNC_IO && out_en_r && !blink_en_r) |=> (o_drive_low == !$past(level_r)))
		else $error("output level not followed");
endmodule : gpiop_pin

// ==== gpiop_bank.sv ====
// Sixteen-pin open-drain multi-function bank with blink divider and peripheral routing
// What this block does
// - Pins open-drain: pull low or release only
// - Pin two resets to slave serial data
// - Pin three resets to slave serial clock
// - Software sets plain pin output level
// - Plain pin reads input or blinks LED
// - Input change sets pending flag when enabled
// - Observe mode enables the driver automatically
// - Second setting picks observed internal signal
// - Management master zero uses pins six, seven
// - Pin zero status at group 1E/0100
`include "gpiop_params.svh"
module gpiop_bank #(
	parameter int BLINK_DIV = `GPIOP_BLINK_DIV
) (
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_rst,
	input  wire logic [`GPIOP_NPINS-1:0]         i_cfg_wr,
	input  wire gpiop_pkg::gpiop_func_type       i_cfg_func,
	input  wire logic                            i_cfg_out_en,
	input  wire logic                            i_cfg_level,
	input  wire logic                            i_cfg_blink_en,
	input  wire logic [`GPIOP_RATE_W-1:0]        i_cfg_blink_rate,
	input  wire logic                            i_cfg_irq_en,
	input  wire logic [`GPIOP_OBS_SEL_W-1:0]     i_cfg_obs_sel,
	input  wire logic [`GPIOP_NPINS-1:0]         i_pend_clr,
	input  wire logic [`GPIOP_OBS_W-1:0]         i_observe,
	input  wire logic [`GPIOP_NPINS-1:0]         i_periph_low,
	input  wire logic                            i_slv_sda_low,
	input  wire logic                            i_slv_scl_low,
	input  wire logic                            i_mm0_sda_low,
	input  wire logic                            i_mm0_scl_low,
	input  wire logic [`GPIOP_NPINS-1:0]         i_pin_in,
	output logic [`GPIOP_NPINS-1:0]              o_pin_out,
	output logic [`GPIOP_NPINS-1:0]              o_pin_oe_n,
	output logic [`GPIOP_NPINS-1:0]              o_pin_level,
	output logic [`GPIOP_NPINS-1:0]              o_pin_pend,
	output logic                                 o_slv_sda_in,
	output logic                                 o_slv_scl_in,
	output logic                                 o_mm0_sda_in,
	output logic                                 o_mm0_scl_in,
	output logic [23:0]                          o_cfg_status_addr
);
	import gpiop_pkg::*;

	localparam int CNT_W = $clog2(BLINK_DIV);

	logic [CNT_W-1:0]          div_r;
	logic [`GPIOP_PHASE_W-1:0] phase_r;
	logic                      tick;
	logic [`GPIOP_NPINS-1:0]   drive_low;
	logic [`GPIOP_NPINS-1:0]   periph_low;
	gpiop_func_type            func_w [`GPIOP_NPINS];

	// -----------------------------------------------------------------
	// Blink rate divider
	// -----------------------------------------------------------------
	// One slow tick feeds a phase counter; each bit is a blink rate
	assign tick = (div_r == CNT_W'(BLINK_DIV - 1));

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_r   <= '0;
			phase_r <= '0;
		end else begin
			div_r   <= tick ? '0 : div_r + 1'b1;
			phase_r <= tick ? phase_r + 1'b1 : phase_r;
		end
	end

	// -----------------------------------------------------------------
	// Peripheral routing
	// -----------------------------------------------------------------
	// Dedicated serial lines replace the generic peripheral drive
	always_comb begin
		periph_low                   = i_periph_low;
		periph_low[`GPIOP_PIN_SSDA]  = i_slv_sda_low;
		periph_low[`GPIOP_PIN_SSCL]  = i_slv_scl_low;
		periph_low[`GPIOP_PIN_MSDA]  = i_mm0_sda_low;
		periph_low[`GPIOP_PIN_MSCL]  = i_mm0_scl_low;
	end

	// Unconfigured serial inputs read as an idle, released line
	assign o_slv_sda_in = (func_w[`GPIOP_PIN_SSDA] == GPIOP_FUNC_PERIPH) ? o_pin_level[`GPIOP_PIN_SSDA] : 1'b1;
	assign o_slv_scl_in = (func_w[`GPIOP_PIN_SSCL] == GPIOP_FUNC_PERIPH) ? o_pin_level[`GPIOP_PIN_SSCL] : 1'b1;
	assign o_mm0_sda_in = (func_w[`GPIOP_PIN_MSDA] == GPIOP_FUNC_PERIPH) ? o_pin_level[`GPIOP_PIN_MSDA] : 1'b1;
	assign o_mm0_scl_in = (func_w[`GPIOP_PIN_MSCL] == GPIOP_FUNC_PERIPH) ? o_pin_level[`GPIOP_PIN_MSCL] : 1'b1;

	// Pin zero status address: channel, group, register number
	assign o_cfg_status_addr = {`GPIOP_CFG_CHAN, `GPIOP_CFG_DEVGRP, `GPIOP_CFG_REGNUM};

	// -----------------------------------------------------------------
	// Pins
	// -----------------------------------------------------------------
	for (genvar p = 0; p < `GPIOP_NPINS; p++) begin : g_pin
		localparam gpiop_func_type RST_F =
			(p == `GPIOP_PIN_SSDA || p == `GPIOP_PIN_SSCL) ? GPIOP_FUNC_PERIPH : GPIOP_FUNC_IO;
		gpiop_pin #(
			.RESET_FUNC (RST_F)
		) i_gpiop_pin (
			.i_sys_clk        (i_sys_clk),
			.i_rst            (i_rst),
			.i_cfg_wr         (i_cfg_wr[p]),
			.i_cfg_func       (i_cfg_func),
			.i_cfg_out_en     (i_cfg_out_en),
			.i_cfg_level      (i_cfg_level),
			.i_cfg_blink_en   (i_cfg_blink_en),
			.i_cfg_blink_rate (i_cfg_blink_rate),
			.i_cfg_irq_en     (i_cfg_irq_en),
			.i_cfg_obs_sel    (i_cfg_obs_sel),
			.i_pend_clr       (i_pend_clr[p]),
			.i_blink_phase    (phase_r),
			.i_observe        (i_observe),
			.i_periph_low     (periph_low[p]),
			.i_pad_in         (i_pin_in[p]),
			.o_drive_low      (drive_low[p]),
			.o_level          (o_pin_level[p]),
			.o_pend           (o_pin_pend[p]),
			.o_func           (func_w[p])
		);
	end

	// Data is always low; the enable alone decides pull or release
	assign o_pin_out  = '0;
	assign o_pin_oe_n = ~drive_low;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	reset_slave_a: assert property (@(posedge i_sys_clk)
		i_rst |=> (func_w[`GPIOP_PIN_SSDA] == GPIOP_FUNC_PERIPH && func_w[`GPIOP_PIN_SSCL] == GPIOP_FUNC_PERIPH))
		else $error("slave serial pins not default after reset");
	mm0_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(func_w[`GPIOP_PIN_MSDA] != GPIOP_FUNC_PERIPH) |-> o_mm0_sda_in)
		else $error("master data seen while pin unassigned");
	mm0_route_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(func_w[`GPIOP_PIN_MSCL] == GPIOP_FUNC_PERIPH) |=> (o_pin_oe_n[`GPIOP_PIN_MSCL] == !$past(i_mm0_scl_low)))
		else $error("master clock not driven on pin seven");
	open_drain_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_pin_out == '0)
		else $error("pin driven high");
endmodule : gpiop_bank

// ==== gpiop_board.sv ====
// Board model: pull-ups and external devices on the open-drain pins
`include "gpiop_params.svh"
module gpiop_board (
	input  wire logic [`GPIOP_NPINS-1:0] i_oe_n,
	input  wire logic [`GPIOP_NPINS-1:0] i_ext_low,
	output logic      [`GPIOP_NPINS-1:0] o_pad
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up gives the high level, so a released pin never floats
	assign o_pad = i_oe_n & ~i_ext_low;
endmodule : gpiop_board

// ==== tb_gpiop_bank.sv ====
// Self-checking bench for the open-drain pin bank
`include "gpiop_params.svh"
module tb_gpiop_bank;
	import gpiop_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_rst = 1;
	logic [15:0] wr = 0, clr = 0, obs = 0, ext = 0, pad, oe_n, pout, lvl, pend;
	gpiop_func_type func = GPIOP_FUNC_IO;
	logic oe = 0, level = 1, blk = 0, irq = 0, ssda = 0, sscl = 0, msda = 0, mscl = 0;
	logic [1:0] rate = 0;
	logic [3:0] sel = 0;
	logic s_sda, s_scl, m_sda, m_scl;
	logic [23:0] addr;
	int num_errors = 0, n_tests = 0;
	// ----------------------------------------------------------
	// Clock, design and board
	// ----------------------------------------------------------
	always #5 i_sys_clk = ~i_sys_clk;
	gpiop_bank #(.BLINK_DIV(4)) i_gpiop_bank (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg_wr(wr),
		.i_cfg_func(func), .i_cfg_out_en(oe), .i_cfg_level(level), .i_cfg_blink_en(blk),
		.i_cfg_blink_rate(rate), .i_cfg_irq_en(irq), .i_cfg_obs_sel(sel), .i_pend_clr(clr),
		.i_observe(obs), .i_periph_low(16'h0000), .i_slv_sda_low(ssda), .i_slv_scl_low(sscl),
		.i_mm0_sda_low(msda), .i_mm0_scl_low(mscl), .i_pin_in(pad), .o_pin_out(pout),
		.o_pin_oe_n(oe_n), .o_pin_level(lvl), .o_pin_pend(pend), .o_slv_sda_in(s_sda),
		.o_slv_scl_in(s_scl), .o_mm0_sda_in(m_sda), .o_mm0_scl_in(m_scl), .o_cfg_status_addr(addr));
	gpiop_board i_gpiop_board (.i_oe_n(oe_n), .i_ext_low(ext), .o_pad(pad));
	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tick
	// Write one pin's setting, then wait until the driver shows it
	task automatic cfg(input int p, input gpiop_func_type f, input logic o, input logic l, input logic b,
		input logic [1:0] r, input logic q, input logic [3:0] s);
		@(posedge i_sys_clk);
		wr[p] <= 1'b1;
		func <= f;
		oe <= o;
		level <= l;
		blk <= b;
		rate <= r;
		irq <= q;
		sel <= s;
		@(posedge i_sys_clk);
		wr <= '0;
		tick(2);
	endtask : cfg
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset;
		chk(oe_n, 16'hFFFF, "reset oe_n");
		chk(pend, 16'h0000, "reset pend");
		chk(pout, 16'h0000, "pin out");
		chk(addr, 24'h1E0100, "status addr");
		@(posedge i_sys_clk);
		ssda <= 1'b1;
		sscl <= 1'b1;
		tick(4);
		chk(oe_n[2], 1'b0, "slave data drive");
		chk(s_sda, 1'b0, "slave data in");
		chk(oe_n[3], 1'b0, "slave clock drive");
		chk(s_scl, 1'b0, "slave clock in");
		ssda <= 1'b0;
		sscl <= 1'b0;
		$display("test reset done");
	endtask : t_reset
	task automatic t_out;
		cfg(4, GPIOP_FUNC_IO, 1, 0, 0, 0, 0, 0);
		chk(oe_n[4], 1'b0, "drive low");
		cfg(4, GPIOP_FUNC_IO, 1, 1, 0, 0, 0, 0);
		chk(oe_n[4], 1'b1, "drive high");
		chk(pout, 16'h0000, "never drives high");
		$display("test out done");
	endtask : t_out
	task automatic t_input;
		cfg(5, GPIOP_FUNC_IO, 0, 1, 0, 0, 1, 0);
		@(posedge i_sys_clk);
		ext[5] <= 1'b1;
		ext[8] <= 1'b1;
		tick(2);
		chk(lvl[5], 1'b0, "sync level");
		chk(pend[5], 1'b0, "pend not yet");
		tick(1);
		chk(pend[5], 1'b1, "pend set");
		chk(pend[8], 1'b0, "pend disabled");
		clr[5] <= 1'b1;
		@(posedge i_sys_clk);
		clr[5] <= 1'b0;
		tick(1);
		chk(pend[5], 1'b0, "pend clear");
		ext <= '0;
		$display("test input done");
	endtask : t_input
	task automatic t_observe;
		obs <= 16'h0008;
		cfg(9, GPIOP_FUNC_OBSERVE, 0, 1, 0, 0, 0, 3);
		chk(oe_n[9], 1'b1, "observe high releases");
		@(posedge i_sys_clk);
		obs <= 16'h0004;
		tick(2);
		chk(oe_n[9], 1'b0, "observe follows");
		obs <= 16'hFFF7;
		tick(2);
		chk(oe_n[9], 1'b0, "observe picks sel");
		cfg(9, GPIOP_FUNC_IO, 0, 1, 0, 0, 0, 3);
		chk(oe_n[9], 1'b1, "switch releases");
		$display("test observe done");
	endtask : t_observe
	task automatic t_mgmt;
		msda <= 1'b1;
		mscl <= 1'b1;
		tick(4);
		chk({oe_n[7:6], m_scl, m_sda}, 4'hF, "mgmt unrouted");
		cfg(6, GPIOP_FUNC_PERIPH, 0, 1, 0, 0, 0, 0);
		cfg(7, GPIOP_FUNC_PERIPH, 0, 1, 0, 0, 0, 0);
		tick(3);
		chk({oe_n[7:6], m_scl, m_sda}, 4'h0, "mgmt routed");
		$display("test mgmt done");
	endtask : t_mgmt
	// Blink: phase bit r toggles every 4 << r cycles with a divider of 4
	task automatic t_blink;
		int lows, chg;
		logic prev;
		for (int r = 0; r < 2; r++) begin
			cfg(12, GPIOP_FUNC_IO, 1, 1, 1, r[1:0], 0, 0);
			lows = 0;
			chg = 0;
			prev = oe_n[12];
			repeat (32) begin
				tick(1);
				lows += (oe_n[12] === 1'b0);
				chg += (oe_n[12] !== prev);
				prev = oe_n[12];
			end
			chk(lows, 16, "blink duty");
			chk(chg, 8 >> r, "blink rate");
		end
		$display("test blink done");
	endtask : t_blink
	// ----------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------
	initial begin
		tick(8);
		i_rst <= 1'b0;
		tick(1);
		t_reset();
		t_out();
		t_input();
		t_observe();
		t_mgmt();
		t_blink();
		wrap_up();
	end
	initial begin
		#20000;
		num_errors++;
		wrap_up();
	end
endmodule : tb_gpiop_bank
